// >>> intc_pkg.sv
// Shared constants and helpers for the interrupt priority and polarity block
package intc_pkg;

  // APB word indexes; byte address is four times the index
  localparam logic [5:0] IDX_MASK     = 6'h00;
  localparam logic [5:0] IDX_POL      = 6'h01;
  localparam logic [5:0] IDX_PRL_LOW  = 6'h02;
  localparam logic [5:0] IDX_PRL_MID  = 6'h03;
  localparam logic [5:0] IDX_PRL_HIGH = 6'h04;
  localparam logic [5:0] IDX_PENDING  = 6'h05;
  localparam logic [5:0] IDX_CLR_PEND = 6'h06;
  localparam logic [5:0] IDX_PRESENT  = 6'h07;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h08;
  localparam logic [5:0] IDX_IRQ_EN   = 6'h09;
  localparam logic [5:0] IDX_IRQ_CLR  = 6'h0a;
  localparam logic [5:0] IDX_LAST     = 6'h0a;

  // Reset values
  localparam logic [7:0] MASK_RST     = 8'h00;
  localparam logic [7:0] POL_RST      = 8'h00;
  localparam logic [7:0] PRL_LOW_RST  = 8'hfa;
  localparam logic [7:0] PRL_MID_RST  = 8'hc6;
  localparam logic [7:0] PRL_HIGH_RST = 8'h88;
  localparam logic [2:0] IRQ_RST      = 3'h0;

  // Polarity fields; bits 7-5 read zero
  localparam int unsigned POL_NMI_BIT = 0;
  localparam int unsigned POL_PA_BIT  = 1;
  localparam int unsigned POL_PB_BIT  = 2;
  localparam logic [7:0]  POL_USED    = 8'h1f;

  // Source codes and vectors
  localparam logic [3:0] SRC_NMI    = 4'h8;
  localparam logic [2:0] SRC_PORT_A = 3'h6;
  localparam logic [2:0] SRC_PORT_B = 3'h7;
  localparam logic [7:0] VEC_BASE   = 8'h03;
  localparam logic [7:0] VEC_STRIDE = 8'h03;
  localparam int unsigned GROUP_W   = 3;
  localparam int unsigned LEVELS    = 8;

  // Interrupt status bits
  localparam int unsigned IRQ_NMI_BIT  = 0;
  localparam int unsigned IRQ_PORT_BIT = 1;
  localparam int unsigned IRQ_ACK_BIT  = 2;

  function automatic logic [7:0] vector_of(input logic [3:0] src);
    vector_of = 8'(8'(src) * VEC_STRIDE + VEC_BASE);
  endfunction : vector_of

  function automatic logic [7:0] onehot8(input logic [2:0] code);
    onehot8 = 8'(8'h01 << code);
  endfunction : onehot8

endpackage : intc_pkg

// >>> pin_edge_detect.sv
// Synchronised edge detector with selectable triggering edge
`timescale 1ns/100ps
module pin_edge_detect (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic srst_i,
  input  wire logic ce_i,
  // Pin and edge choice
  input  wire logic pin_i,
  input  wire logic fall_sel_i,
  // Event
  output logic      edge_o
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  wire  rise_w = sync2_reg & ~prev_reg;
  wire  fall_w = ~sync2_reg & prev_reg;
  wire  edge_next = fall_sel_i ? fall_w : rise_w;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
      edge_o    <= 1'b0;
    end else if (ce_i) begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
      edge_o    <= edge_next;
    end
  end

  a_edge_selected: assert property (@(posedge clock_i) disable iff (srst_i) // RQ1
    (ce_i && (fall_sel_i ? fall_w : rise_w)) |=> edge_o)
    else $error("selected edge not reported");
  a_edge_quiet: assert property (@(posedge clock_i) disable iff (srst_i) // RQ12
    (ce_i && sync2_reg == prev_reg) |=> !edge_o)
    else $error("edge reported without a pin change");

endmodule : pin_edge_detect

// >>> priority_select.sv
// Finds the highest programmable level whose coded source is requesting
`timescale 1ns/100ps
module priority_select (
  // Priority map and requests
  input  wire logic [23:0] map_i,
  input  wire logic [7:0]  req_i,
  // Winner
  output logic             found_o,
  output logic [2:0]       code_o,
  output logic [2:0]       level_o
);
  logic [2:0] grp;

  // Scan from the lowest level up so the highest level is written last
  always_comb begin
    grp     = 3'h0;
    found_o = 1'b0;
    code_o  = 3'h0;
    level_o = 3'h0;
    for (int l = intc_pkg::LEVELS - 1; l >= 0; l--) begin
      grp = map_i[l*intc_pkg::GROUP_W +: intc_pkg::GROUP_W]; // RQ3 RQ5 RQ6
      if (req_i[grp]) begin
        found_o = 1'b1;
        code_o  = grp;
        level_o = 3'(l);
      end
    end
  end
  // A code held in two groups takes the higher level; software keeps them distinct RQ8

endmodule : priority_select

// >>> interrupt_priority_polarity_config.sv
// Interrupt configuration, pending tracking and request selection toward the core
//
// Behaviour
// RQ1: Port A polarity 0 triggers on a rising pin edge, 1 on a falling edge.
// RQ2: NMI polarity 0 triggers on a rising input edge, 1 on a falling edge.
// RQ3: The three priority registers form one 24-bit map of eight 3-bit level groups, level 1 highest.
// RQ4: The NMI sits at fixed level 0 above all others and only the trap may preempt its service.
// RQ5: Bits 2-0 define level 1 and each higher group the next lower level, up to bits 23-21 as level 8.
// RQ6: Each group holds a source code 0..7 (converter, timer 0, timer 1, serial, SPI, I2C, port A, port B).
// RQ7: Reset loads the low, mid and high maps with fa, c6 and 88, putting code n at level n plus one.
// RQ8: Software keeps every group code distinct and the three registers consistent.
// RQ9: A source with mask bit 1 may be presented; with mask 0 its request stays pending.
// RQ10: Writing a new NMI or port polarity raises a request from that source.
// RQ11: A pending higher-level request preempts a lower-level service, checked at instruction boundaries.
// RQ12: Port B polarity 0 triggers on a rising input edge, 1 on a falling edge.
// RQ13: Among enabled pending requests the one in the highest level group is presented with its vector.
// RQ14: Each detected edge stays pending until serviced or explicitly cleared.
//
// Our own choice: the APB register port.
`timescale 1ns/100ps
module interrupt_priority_polarity_config (
  // Clock, reset, enable
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  input  wire logic        ce_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Event sources
  input  wire logic [5:0]  periph_event_i,
  input  wire logic        nmi_pin_i,
  input  wire logic        port_a_pin_i,
  input  wire logic        port_b_pin_i,
  // Core control unit
  input  wire logic        instr_boundary_i,
  input  wire logic        ack_i,
  input  wire logic        reti_i,
  input  wire logic        trap_busy_i,
  output logic             irq_req_o,
  output logic [3:0]       irq_source_o,
  output logic [7:0]       irq_vector_o,
  // Interrupt line
  output logic             irq_o
);
  logic [7:0] mask_reg, pol_reg, prl_low_reg, prl_mid_reg, prl_high_reg;
  logic [7:0] pend_reg, isr_reg;
  logic       nmi_pend_reg, nmi_isr_reg;
  logic [2:0] irq_stat_reg, irq_en_reg;
  logic [7:0] rd_data;
  logic       nmi_edge, pa_edge, pb_edge;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire [5:0] idx      = paddr_i[7:2];
  wire       addr_ok  = (paddr_i[1:0] == 2'h0) && (idx <= intc_pkg::IDX_LAST);
  wire       setup    = psel_i & ~penable_i;
  wire       wr_acc   = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o & pstrb_i[0];
  wire [7:0] wbyte    = pwdata_i[7:0];
  wire       wr_mask  = wr_acc && idx == intc_pkg::IDX_MASK;
  wire       wr_pol   = wr_acc && idx == intc_pkg::IDX_POL;
  wire       wr_low   = wr_acc && idx == intc_pkg::IDX_PRL_LOW;
  wire       wr_mid   = wr_acc && idx == intc_pkg::IDX_PRL_MID;
  wire       wr_high  = wr_acc && idx == intc_pkg::IDX_PRL_HIGH;
  wire       wr_clrp  = wr_acc && idx == intc_pkg::IDX_CLR_PEND;
  wire       wr_irqen = wr_acc && idx == intc_pkg::IDX_IRQ_EN;
  wire       wr_irqcl = wr_acc && idx == intc_pkg::IDX_IRQ_CLR;

  wire [23:0] prio_map = {prl_low_reg, prl_mid_reg, prl_high_reg}; // RQ3 RQ5

  always_comb begin
    case (idx)
      intc_pkg::IDX_MASK:     rd_data = mask_reg;
      intc_pkg::IDX_POL:      rd_data = pol_reg;
      intc_pkg::IDX_PRL_LOW:  rd_data = prl_low_reg;
      intc_pkg::IDX_PRL_MID:  rd_data = prl_mid_reg;
      intc_pkg::IDX_PRL_HIGH: rd_data = prl_high_reg;
      intc_pkg::IDX_PENDING:  rd_data = pend_reg;
      intc_pkg::IDX_PRESENT:  rd_data = {2'h0, nmi_isr_reg, nmi_pend_reg, irq_source_o};
      intc_pkg::IDX_IRQ_STAT: rd_data = {5'h00, irq_stat_reg};
      intc_pkg::IDX_IRQ_EN:   rd_data = {5'h00, irq_en_reg};
      default:                rd_data = 8'h00;
    endcase
  end

  // Answer is prepared in setup so the access phase completes with no wait
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else if (ce_i) begin
      pready_o  <= setup;
      pslverr_o <= setup & ~addr_ok;
      if (setup) begin
        prdata_o <= {24'h00_0000, (addr_ok && !pwrite_i) ? rd_data : 8'h00};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection
  pin_edge_detect u_nmi_edge (
    .clock_i    (clock_i),
    .srst_i     (srst_i),
    .ce_i       (ce_i),
    .pin_i      (nmi_pin_i),
    .fall_sel_i (pol_reg[intc_pkg::POL_NMI_BIT]), // RQ2
    .edge_o     (nmi_edge)
  );
  pin_edge_detect u_pa_edge (
    .clock_i    (clock_i),
    .srst_i     (srst_i),
    .ce_i       (ce_i),
    .pin_i      (port_a_pin_i),
    .fall_sel_i (pol_reg[intc_pkg::POL_PA_BIT]), // RQ1
    .edge_o     (pa_edge)
  );
  pin_edge_detect u_pb_edge (
    .clock_i    (clock_i),
    .srst_i     (srst_i),
    .ce_i       (ce_i),
    .pin_i      (port_b_pin_i),
    .fall_sel_i (pol_reg[intc_pkg::POL_PB_BIT]), // RQ12
    .edge_o     (pb_edge)
  );

  // Changing a polarity looks like an edge to the source, so it requests
  wire nmi_chg = wr_pol && (wbyte[intc_pkg::POL_NMI_BIT] != pol_reg[intc_pkg::POL_NMI_BIT]); // RQ10
  wire pa_chg  = wr_pol && (wbyte[intc_pkg::POL_PA_BIT] != pol_reg[intc_pkg::POL_PA_BIT]);   // RQ10
  wire pb_chg  = wr_pol && (wbyte[intc_pkg::POL_PB_BIT] != pol_reg[intc_pkg::POL_PB_BIT]);   // RQ10

  ////////////////////////////////////////////////////////////////////////////
  // Selection
  logic       win_found, isr_found;
  logic [2:0] win_code, win_lvl, isr_code, isr_lvl;

  priority_select u_win_sel (
    .map_i   (prio_map),
    .req_i   (pend_reg & mask_reg), // RQ9
    .found_o (win_found),
    .code_o  (win_code),
    .level_o (win_lvl)
  );
  priority_select u_isr_sel (
    .map_i   (prio_map),
    .req_i   (isr_reg),
    .found_o (isr_found),
    .code_o  (isr_code),
    .level_o (isr_lvl)
  );

  wire       blocked   = trap_busy_i | nmi_isr_reg; // RQ4
  wire       cand_nmi  = nmi_pend_reg & ~blocked; // RQ4
  wire       cand_prog = win_found & ~blocked & (~isr_found | (win_lvl < isr_lvl)); // RQ11 RQ13
  wire [3:0] cand_src  = cand_nmi ? intc_pkg::SRC_NMI : {1'b0, win_code};

  ////////////////////////////////////////////////////////////////////////////
  // Pending and in-service state
  wire       ack_take  = ack_i & irq_req_o;
  wire       ack_nmi   = ack_take && irq_source_o == intc_pkg::SRC_NMI;
  wire [7:0] ack_vec   = (ack_take && !irq_source_o[3]) ? intc_pkg::onehot8(irq_source_o[2:0]) : 8'h00;
  wire [7:0] sw_clr    = (wr_clrp && !wbyte[3]) ? intc_pkg::onehot8(wbyte[2:0]) : 8'h00;
  wire       sw_clrnmi = wr_clrp && wbyte[3:0] == intc_pkg::SRC_NMI;
  wire [7:0] set_vec   = {pb_edge | pb_chg, pa_edge | pa_chg, periph_event_i};
  wire [7:0] reti_vec  = (reti_i && !nmi_isr_reg && isr_found) ? intc_pkg::onehot8(isr_code) : 8'h00;
  // Clearing a source under service has no effect; a new event wins over any clear
  wire [7:0] pend_next = (pend_reg & ~(sw_clr & ~isr_reg) & ~ack_vec) | set_vec; // RQ14
  wire       nmi_next  = (nmi_pend_reg & ~ack_nmi & ~(sw_clrnmi & ~nmi_isr_reg)) | nmi_edge | nmi_chg; // RQ14
  wire [7:0] isr_next  = (isr_reg & ~reti_vec) | ack_vec;
  wire       nisr_next = (nmi_isr_reg & ~reti_i) | ack_nmi;
  wire [2:0] irq_set   = {ack_take, pa_edge | pb_edge, nmi_edge};
  wire [2:0] stat_next = (irq_stat_reg & ~(wr_irqcl ? wbyte[2:0] : 3'h0)) | irq_set;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      mask_reg     <= intc_pkg::MASK_RST;
      pol_reg      <= intc_pkg::POL_RST;
      prl_low_reg  <= intc_pkg::PRL_LOW_RST; // RQ7
      prl_mid_reg  <= intc_pkg::PRL_MID_RST; // RQ7
      prl_high_reg <= intc_pkg::PRL_HIGH_RST; // RQ7
      irq_en_reg   <= intc_pkg::IRQ_RST;
    end else if (ce_i) begin
      if (wr_mask)  mask_reg     <= wbyte;
      if (wr_pol)   pol_reg      <= wbyte & intc_pkg::POL_USED;
      if (wr_low)   prl_low_reg  <= wbyte;
      if (wr_mid)   prl_mid_reg  <= wbyte;
      if (wr_high)  prl_high_reg <= wbyte;
      if (wr_irqen) irq_en_reg   <= wbyte[2:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pend_reg     <= 8'h00;
      nmi_pend_reg <= 1'b0;
      isr_reg      <= 8'h00;
      nmi_isr_reg  <= 1'b0;
      irq_stat_reg <= intc_pkg::IRQ_RST;
      irq_o        <= 1'b0;
    end else if (ce_i) begin
      pend_reg     <= pend_next;
      nmi_pend_reg <= nmi_next;
      isr_reg      <= isr_next;
      nmi_isr_reg  <= nisr_next;
      irq_stat_reg <= stat_next;
      irq_o        <= |(stat_next & irq_en_reg);
    end
  end

  // Presented request changes only at a boundary; acknowledge withdraws it
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      irq_req_o    <= 1'b0;
      irq_source_o <= 4'h0;
      irq_vector_o <= 8'h00;
    end else if (ce_i) begin
      if (ack_take) begin
        irq_req_o <= 1'b0;
      end else if (instr_boundary_i) begin
        irq_req_o    <= cand_nmi | cand_prog; // RQ11 RQ13
        irq_source_o <= cand_src;
        irq_vector_o <= intc_pkg::vector_of(cand_src); // RQ13
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  wire latch_now = ce_i && instr_boundary_i && !ack_take;

  a_nmi_first: assert property ( // RQ4
    (latch_now && nmi_pend_reg && !nmi_isr_reg && !trap_busy_i) |=>
      (irq_req_o && irq_source_o == intc_pkg::SRC_NMI))
    else $error("pending NMI not presented first");
  a_nmi_unpreempted: assert property ( // RQ4
    (latch_now && (nmi_isr_reg || trap_busy_i)) |=> !irq_req_o)
    else $error("request presented during NMI or trap service");
  a_mask_holds: assert property ( // RQ9
    latch_now |=> (!irq_req_o || irq_source_o[3]
      || ((intc_pkg::onehot8(irq_source_o[2:0]) & $past(mask_reg)) != 8'h00)))
    else $error("masked source presented");
  a_pol_write_req: assert property ( // RQ10
    (ce_i && pa_chg) |=> pend_reg[intc_pkg::SRC_PORT_A])
    else $error("polarity write raised no port A request");
  a_reset_map: assert property (disable iff (1'b0) // RQ7
    srst_i |=> (prio_map == {intc_pkg::PRL_LOW_RST, intc_pkg::PRL_MID_RST, intc_pkg::PRL_HIGH_RST}))
    else $error("priority map not at default after reset");
  a_pend_sticky: assert property ( // RQ14
    (ce_i && pend_reg[intc_pkg::SRC_PORT_B] && !ack_vec[intc_pkg::SRC_PORT_B] && !wr_clrp) |=>
      pend_reg[intc_pkg::SRC_PORT_B])
    else $error("port B request lost");
  a_preempt_win: assert property ( // RQ11
    (latch_now && !cand_nmi && cand_prog) |=> (irq_req_o && irq_source_o == {1'b0, $past(win_code)}
      && irq_vector_o == intc_pkg::vector_of({1'b0, $past(win_code)})))
    else $error("winning request not presented");
  a_winner_level: assert property ( // RQ13
    win_found |-> ((pend_reg & mask_reg
      & intc_pkg::onehot8(prio_map[win_lvl*intc_pkg::GROUP_W +: intc_pkg::GROUP_W])) != 8'h00))
    else $error("winner group does not hold a requesting source");
  a_irq_line: assert property (
    ce_i |=> (irq_o == |($past(stat_next) & $past(irq_en_reg))))
    else $error("interrupt line disagrees with status");
  a_reset_quiet: assert property (disable iff (1'b0)
    srst_i |=> (!irq_req_o && !irq_o && pend_reg == 8'h00 && !nmi_pend_reg))
    else $error("request state not cleared by reset");
  a_nmi_edge_pend: assert property ( // RQ2
    (ce_i && nmi_edge) |=> nmi_pend_reg)
    else $error("NMI edge not pending");
  a_pa_edge_pend: assert property ( // RQ1
    (ce_i && pa_edge) |=> pend_reg[intc_pkg::SRC_PORT_A])
    else $error("port A edge not pending");
  a_pb_edge_pend: assert property ( // RQ12
    (ce_i && pb_edge) |=> pend_reg[intc_pkg::SRC_PORT_B])
    else $error("port B edge not pending");
  a_pol_nmi_req: assert property ( // RQ10
    (ce_i && nmi_chg) |=> nmi_pend_reg)
    else $error("polarity write raised no NMI request");
  a_pol_pb_req: assert property ( // RQ10
    (ce_i && pb_chg) |=> pend_reg[intc_pkg::SRC_PORT_B])
    else $error("polarity write raised no port B request");
  a_ack_clears_pend: assert property ( // RQ14
    (ce_i && (ack_vec & ~set_vec) != 8'h00) |=> ((pend_reg & $past(ack_vec & ~set_vec)) == 8'h00))
    else $error("acknowledged request still pending");
  a_lower_blocked: assert property ( // RQ11
    (latch_now && !nmi_pend_reg && isr_found && !(win_found && win_lvl < isr_lvl)) |=> !irq_req_o)
    else $error("request presented without beating the level in service");
  a_reti_ends_nmi: assert property ( // RQ4
    (ce_i && reti_i && nmi_isr_reg && !ack_nmi) |=> !nmi_isr_reg)
    else $error("NMI service not ended by return");
  a_reti_ends_level: assert property ( // RQ11
    (ce_i && reti_i && !nmi_isr_reg && isr_found && !ack_take) |=> !isr_reg[$past(isr_code)])
    else $error("level service not ended by return");

  c_nmi_taken: cover property (irq_req_o && irq_source_o == intc_pkg::SRC_NMI && ack_i);
  c_preempt: cover property (latch_now && isr_found && cand_prog);
  c_pol_write: cover property (ce_i && (pa_chg || pb_chg || nmi_chg));
  c_masked_wait: cover property (pend_reg != 8'h00 && (pend_reg & mask_reg) == 8'h00);
  c_nmi_return: cover property (reti_i && nmi_isr_reg);

endmodule : interrupt_priority_polarity_config

// >>> core_ctrl_model.sv
// Behavioural model of the core control unit that takes presented interrupt requests
`timescale 1ns/100ps
module core_ctrl_model (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       srst_i,
  // Request from the interrupt block
  input  wire logic       irq_req_i,
  input  wire logic [3:0] irq_source_i,
  input  wire logic [7:0] irq_vector_i,
  // Bench control
  input  wire logic [3:0] ack_delay_i,
  input  wire logic       end_isr_i,
  // Toward the interrupt block
  output logic            boundary_o,
  output logic            ack_o,
  output logic            reti_o,
  output logic            trap_busy_o,
  // Log of the last request taken
  output logic [3:0]      taken_src_o,
  output logic [7:0]      taken_vec_o,
  output logic [7:0]      taken_cnt_o
);
  logic [1:0] tick_reg;
  logic [3:0] wait_reg;

  // No trap instruction is ever run by this model
  assign trap_busy_o = 1'b0;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      tick_reg    <= 2'h0;
      wait_reg    <= 4'h0;
      boundary_o  <= 1'b0;
      ack_o       <= 1'b0;
      reti_o      <= 1'b0;
      taken_src_o <= 4'h0;
      taken_vec_o <= 8'h00;
      taken_cnt_o <= 8'h00;
    end else begin
      tick_reg <= tick_reg + 2'h1;
      // Boundaries held off while a request waits, so an ack never meets a re-evaluation
      boundary_o <= (tick_reg == 2'h3) && !irq_req_i;
      reti_o     <= end_isr_i;
      ack_o      <= 1'b0;
      wait_reg   <= 4'h0;
      if (irq_req_i && !ack_o) begin
        wait_reg <= wait_reg + 4'h1;
        if (wait_reg == ack_delay_i) begin
          ack_o       <= 1'b1;
          wait_reg    <= 4'h0;
          taken_src_o <= irq_source_i;
          taken_vec_o <= irq_vector_i;
          taken_cnt_o <= taken_cnt_o + 8'h01;
        end
      end
    end
  end
endmodule : core_ctrl_model

// >>> tb.sv
// Self-checking bench for the interrupt priority and polarity block
`timescale 1ns/100ps
module tb;
  logic clock_i, srst_i, psel, penable, pwrite, nmi_pin, end_isr;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  logic [5:0] periph;
  logic [1:0] port_pins;
  logic [3:0] ack_delay;
  logic [7:0] cnt_exp;
  logic err;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, boundary, ack, reti, trap_busy, irq_req, irq;
  wire logic [3:0] irq_src, taken_src;
  wire logic [7:0] irq_vec, taken_vec, taken_cnt;
  int n_mismatch, check_count, cycles;

  interrupt_priority_polarity_config dut_u (
    .clock_i(clock_i), .srst_i(srst_i), .ce_i(1'b1), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .periph_event_i(periph), .nmi_pin_i(nmi_pin),
    .port_a_pin_i(port_pins[0]), .port_b_pin_i(port_pins[1]), .instr_boundary_i(boundary),
    .ack_i(ack), .reti_i(reti), .trap_busy_i(trap_busy), .irq_req_o(irq_req),
    .irq_source_o(irq_src), .irq_vector_o(irq_vec), .irq_o(irq));

  core_ctrl_model core_u (
    .clock_i(clock_i), .srst_i(srst_i), .irq_req_i(irq_req), .irq_source_i(irq_src),
    .irq_vector_i(irq_vec), .ack_delay_i(ack_delay), .end_isr_i(end_isr), .boundary_o(boundary),
    .ack_o(ack), .reti_o(reti), .trap_busy_o(trap_busy), .taken_src_o(taken_src),
    .taken_vec_o(taken_vec), .taken_cnt_o(taken_cnt));

  always #10 clock_i = ~clock_i;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
    end
  endtask : check

  // Request held until pready is seen high at a rising edge, then released for one idle cycle
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge clock_i);
    penable <= 1'b1;
    @(posedge clock_i);
    while (pready !== 1'b1) @(posedge clock_i);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_i);
  endtask : apb

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    check(rd, exp);
  endtask : rd_chk

  task automatic ev(input logic [5:0] m);
    periph <= m;
    @(posedge clock_i);
    periph <= 6'h00;
    @(posedge clock_i);
  endtask : ev

  // Pins pass two sync flops and the detector, so eight cycles is ample
  task automatic pin(input int p, input logic v);
    if (p == 2) nmi_pin <= v;
    else port_pins[p] <= v;
    repeat (8) @(posedge clock_i);
  endtask : pin

  task automatic take(input logic [3:0] s);
    int n;
    n = 0;
    while (taken_cnt === cnt_exp && n < 300) begin
      @(posedge clock_i);
      n++;
    end
    cnt_exp = cnt_exp + 8'h01;
    check({24'h0, taken_cnt}, {24'h0, cnt_exp});
    check({28'h0, taken_src}, {28'h0, s});
    check({24'h0, taken_vec}, 32'h3 + 32'h3 * s);
  endtask : take

  task automatic idle(input int n);
    repeat (n) @(posedge clock_i);
    check({24'h0, taken_cnt}, {24'h0, cnt_exp});
  endtask : idle

  task automatic finish_isr;
    end_isr <= 1'b1;
    @(posedge clock_i);
    end_isr <= 1'b0;
    repeat (3) @(posedge clock_i);
  endtask : finish_isr

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      final_report;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'b0; srst_i = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; periph = 6'h00; nmi_pin = 1'b0; port_pins = 2'h0;
    ack_delay = 4'h0; end_isr = 1'b0; cnt_exp = 8'h00;
    n_mismatch = 0; check_count = 0; cycles = 0;
    repeat (20) @(posedge clock_i);
    srst_i <= 1'b0;
    @(posedge clock_i);
    rd_chk(intc_pkg::IDX_PRL_LOW, 32'hfa);
    rd_chk(intc_pkg::IDX_PRL_MID, 32'hc6);
    rd_chk(intc_pkg::IDX_PRL_HIGH, 32'h88);
    rd_chk(intc_pkg::IDX_POL, 32'h0);
    apb(1'b0, 6'h0b, 8'h00);
    check({31'h0, err}, 32'h1);
    wr(intc_pkg::IDX_MASK, 8'hff);
    for (int c = 0; c < 6; c++) begin
      ev(6'(1 << c));
      take(4'(c));
      finish_isr;
    end
    // Ack events latch in status; the line follows only while enabled
    rd_chk(intc_pkg::IDX_IRQ_STAT, 32'h4);
    check({31'h0, irq}, 32'h0);
    wr(intc_pkg::IDX_IRQ_EN, 8'h04);
    // Line is registered from the enable, so it follows one cycle later
    @(posedge clock_i);
    check({31'h0, irq}, 32'h1);
    wr(intc_pkg::IDX_IRQ_CLR, 8'h04);
    check({31'h0, irq}, 32'h0);
    rd_chk(intc_pkg::IDX_IRQ_STAT, 32'h0);
    // Masked requests stay pending, then resolve in level order
    wr(intc_pkg::IDX_MASK, 8'h00);
    ev(6'h0a);
    rd_chk(intc_pkg::IDX_PENDING, 32'h0a);
    idle(12);
    wr(intc_pkg::IDX_MASK, 8'hff);
    take(4'h1);
    finish_isr;
    take(4'h3);
    finish_isr;
    wr(intc_pkg::IDX_MASK, 8'h00);
    wr(intc_pkg::IDX_PRL_HIGH, 8'h8b);
    wr(intc_pkg::IDX_PRL_MID, 8'hc0);
    ev(6'h0a);
    wr(intc_pkg::IDX_MASK, 8'hff);
    take(4'h3);
    finish_isr;
    take(4'h1);
    finish_isr;
    wr(intc_pkg::IDX_PRL_HIGH, 8'h88);
    wr(intc_pkg::IDX_PRL_MID, 8'hc6);
    // Nested service: only a higher level breaks in
    ev(6'h04);
    take(4'h2);
    ev(6'h10);
    idle(16);
    ev(6'h01);
    take(4'h0);
    finish_isr;
    idle(16);
    finish_isr;
    take(4'h4);
    finish_isr;
    wr(intc_pkg::IDX_MASK, 8'h00);
    ev(6'h20);
    rd_chk(intc_pkg::IDX_PENDING, 32'h20);
    wr(intc_pkg::IDX_CLR_PEND, 8'h05);
    rd_chk(intc_pkg::IDX_PENDING, 32'h0);
    for (int p = 0; p < 2; p++) begin
      pin(p, 1'b1);
      rd_chk(intc_pkg::IDX_PENDING, 32'h40 << p);
      wr(intc_pkg::IDX_CLR_PEND, 8'(6 + p));
      wr(intc_pkg::IDX_POL, 8'(8'h02 << p));
      rd_chk(intc_pkg::IDX_PENDING, 32'h40 << p);
      wr(intc_pkg::IDX_CLR_PEND, 8'(6 + p));
      pin(p, 1'b0);
      rd_chk(intc_pkg::IDX_PENDING, 32'h40 << p);
      wr(intc_pkg::IDX_CLR_PEND, 8'(6 + p));
      pin(p, 1'b1);
      rd_chk(intc_pkg::IDX_PENDING, 32'h0);
      wr(intc_pkg::IDX_POL, 8'h00);
      wr(intc_pkg::IDX_CLR_PEND, 8'(6 + p));
      pin(p, 1'b0);
      rd_chk(intc_pkg::IDX_PENDING, 32'h0);
    end
    // Slow core from here on; the NMI outranks every programmable level
    ack_delay <= 4'h5;
    ev(6'h01);
    pin(2, 1'b1);
    take(4'h8);
    wr(intc_pkg::IDX_MASK, 8'hff);
    idle(16);
    rd_chk(intc_pkg::IDX_PRESENT, 32'h20);
    finish_isr;
    take(4'h0);
    finish_isr;
    wr(intc_pkg::IDX_POL, 8'h01);
    take(4'h8);
    finish_isr;
    pin(2, 1'b0);
    take(4'h8);
    finish_isr;
    pin(2, 1'b1);
    idle(16);
    final_report;
  end
endmodule : tb
